// ---- hdl/dbsi_ctrl.sv ----
/*
 * Memory controller end: makes the input strobe pair by dividing clk
 * by four, holds the output strobe pair high, runs one burst at a time.
 * Assumes the device answers on the input strobe pair.
 */
`timescale 1ns/10ps
module dbsi_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    dbsi_link_if.ctl                   link,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_read,
    input  wire dbsi_pkg::dbsi_addr_t  req_addr,
    input  wire logic [dbsi_pkg::BURST*dbsi_pkg::DW-1:0] req_wdata,
    input  wire logic [dbsi_pkg::BURST*dbsi_pkg::LANES-1:0] req_wmask_n,
    output logic                       rsp_valid,
    output logic [dbsi_pkg::BURST*dbsi_pkg::DW-1:0] rsp_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0]                ph_reg;
    dbsi_pkg::dbsi_ctl_e       state_reg;
    dbsi_pkg::dbsi_ctl_e       state_next;
    dbsi_pkg::dbsi_slot_t      slot_reg;
    logic                      op_rd_reg;
    logic                      load_n_reg;
    logic                      rw_reg;
    dbsi_pkg::dbsi_addr_t      addr_reg;
    logic [dbsi_pkg::BURST*dbsi_pkg::DW-1:0]    wdata_reg;
    logic [dbsi_pkg::BURST*dbsi_pkg::LANES-1:0] wmask_reg;
    dbsi_pkg::dbsi_word_t      dout_reg;
    logic                      doe_reg;
    dbsi_pkg::dbsi_mask_t      mask_out_reg;
    logic                      rsp_valid_reg;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic busy = state_reg == dbsi_pkg::CTL_BUSY;
    wire logic mid  = !ph_reg[0];
    wire logic step = busy && mid;
    wire logic take = req_valid && req_ready;
    wire logic wr_beat = step && !op_rd_reg &&
        slot_reg >= dbsi_pkg::SLOT_WR_FRST &&
        slot_reg <= dbsi_pkg::SLOT_WR_LAST;
    wire logic rd_beat = step && op_rd_reg &&
        slot_reg >= dbsi_pkg::SLOT_RD_FRST;
    wire dbsi_pkg::dbsi_beat_t wr_idx =
        dbsi_pkg::dbsi_beat_t'(slot_reg - dbsi_pkg::SLOT_WR_FRST);
    wire dbsi_pkg::dbsi_beat_t rd_idx =
        dbsi_pkg::dbsi_beat_t'(slot_reg - dbsi_pkg::SLOT_RD_FRST);
    wire logic done = step && slot_reg == dbsi_pkg::SLOT_LAST;

    // One load per four strobe periods
    assign req_ready = !busy && ph_reg == dbsi_pkg::PH_RST;

    always_comb
    begin
        case (state_reg)
            dbsi_pkg::CTL_IDLE: state_next = take ? dbsi_pkg::CTL_BUSY
                                                  : dbsi_pkg::CTL_IDLE;
            dbsi_pkg::CTL_BUSY: state_next = done ? dbsi_pkg::CTL_IDLE
                                                  : dbsi_pkg::CTL_BUSY;
            default:            state_next = dbsi_pkg::CTL_IDLE;
        endcase
    end

    wire dbsi_pkg::dbsi_slot_t slot_next =
        take ? dbsi_pkg::dbsi_slot_t'(dbsi_pkg::SLOT_LOAD + 1'b1) :
        step ? dbsi_pkg::dbsi_slot_t'(slot_reg + 1'b1) : slot_reg;
    wire logic load_n_next = take ? 1'b0 :
        (step && slot_reg == dbsi_pkg::SLOT_LOADEND) ? 1'b1 : load_n_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ph_reg        <= dbsi_pkg::PH_RST;
            state_reg     <= dbsi_pkg::CTL_IDLE;
            slot_reg      <= dbsi_pkg::SLOT_LOAD;
            op_rd_reg     <= 1'b0;
            load_n_reg    <= 1'b1;
            rw_reg        <= 1'b0;
            addr_reg      <= dbsi_pkg::ADDR_RST;
            wdata_reg     <= '0;
            wmask_reg     <= '1;
            dout_reg      <= dbsi_pkg::WORD_RST;
            doe_reg       <= 1'b0;
            mask_out_reg  <= dbsi_pkg::MASK_NONE;
            rsp_valid_reg <= 1'b0;
        end
        else
        begin
            ph_reg        <= 2'(ph_reg + 1'b1);
            state_reg     <= state_next;
            slot_reg      <= slot_next;
            load_n_reg    <= load_n_next;
            rsp_valid_reg <= done && op_rd_reg;
            if (take)
            begin
                op_rd_reg <= req_read;
                rw_reg    <= req_read;
                addr_reg  <= req_addr;
                wdata_reg <= req_wdata;
                wmask_reg <= req_wmask_n;
            end
            if (step)
            begin
                doe_reg <= wr_beat;
            end
            if (wr_beat)
            begin
                dout_reg     <= wdata_reg[wr_idx*dbsi_pkg::DW +: dbsi_pkg::DW];
                mask_out_reg <=
                    wmask_reg[wr_idx*dbsi_pkg::LANES +: dbsi_pkg::LANES];
            end
        end
    end

    // ------------------------------------------------------------
    // Read capture, one register per word
    // ------------------------------------------------------------
    genvar gw;
    generate
        for (gw = 0; gw < dbsi_pkg::BURST; gw++)
        begin : g_word
            dbsi_pkg::dbsi_word_t word_reg;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    word_reg <= dbsi_pkg::WORD_RST;
                else if (rd_beat && rd_idx == dbsi_pkg::dbsi_beat_t'(gw))
                    word_reg <= link.shared_data_lines;
            end
            assign rsp_rdata[gw*dbsi_pkg::DW +: dbsi_pkg::DW] = word_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------
    assign link.k_clk             = ph_reg[1];
    assign link.k_clk_n           = !ph_reg[1];
    assign link.c_clk             = 1'b1;
    assign link.c_clk_n           = 1'b1;
    assign link.cycle_load_n      = load_n_reg;
    assign link.read_not_write    = rw_reg;
    assign link.addr              = addr_reg;
    assign link.byte_write_mask_n = mask_out_reg;
    assign link.ctl_data_out      = dout_reg;
    assign link.ctl_data_oe       = doe_reg;
    assign rsp_valid              = rsp_valid_reg;

endmodule

// ---- hdl/dbsi_device.sv ----
/*
 * Memory device end: burst-of-four double data rate memory, x36.
 * Runs on the link's input strobe pair; assumes the output strobe pair
 * is either held high or has the input strobe frequency.
 */
`timescale 1ns/10ps
// Summary of operation
// - Address and control taken on true strobe rise
// - Every transfer moves exactly four words
// - Two low address bits pick start word
// - Address ignored when idle or mid-burst
// - Write data taken on both strobe rises
// - Data bus is 36 lines wide
// - Low load input at rise starts cycle
// - Direction high reads, low writes
// - Only unmasked byte lanes are written
// - Controller gives a mask per beat
// - Words one, three on complement output rise
// - Words two, four on true output rise
// - Held-high output pair selects input strobes
// - Echo strobes follow output timing, free-running
// - Bypass input low skips the delay loop
// - Unused balls report their applied level
// - Low bits advance modulo four, end at four
// - Read words from complement rise of t+1
// - Write words on rises of t+1, t+2
module dbsi_device
(
    dbsi_link_if.dev                   link,
    input  wire logic                  rst,
    input  wire logic                  dll_bypass_n,
    output logic                       dll_ready,
    input  wire logic [dbsi_pkg::NC_W-1:0] nc_level,
    output logic [dbsi_pkg::NC_W-1:0]  scan_nc_level
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic dbsi_pkg::dbsi_addr_t burst_addr
    (
        input dbsi_pkg::dbsi_addr_t base,
        input dbsi_pkg::dbsi_beat_t off
    );
        dbsi_pkg::dbsi_beat_t low;
        low = dbsi_pkg::dbsi_beat_t'(base[1:0] + off);
        burst_addr = {base[dbsi_pkg::AW-1:2], low};
    endfunction

    function automatic dbsi_pkg::dbsi_word_t merge
    (
        input dbsi_pkg::dbsi_word_t old_w,
        input dbsi_pkg::dbsi_word_t new_w,
        input dbsi_pkg::dbsi_mask_t mask_n,
        input logic                 en
    );
        merge = old_w;
        for (int l = 0; l < dbsi_pkg::LANES; l++)
        begin
            if (en && !mask_n[l])
            begin
                merge[l*dbsi_pkg::LANE_W +: dbsi_pkg::LANE_W] =
                    new_w[l*dbsi_pkg::LANE_W +: dbsi_pkg::LANE_W];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Command pipeline on the true input strobe
    // ------------------------------------------------------------
    logic                 p1_vld_reg;
    logic                 p1_rd_reg;
    dbsi_pkg::dbsi_addr_t p1_base_reg;
    logic                 p2_vld_reg;
    logic                 p2_rd_reg;
    dbsi_pkg::dbsi_addr_t p2_base_reg;
    logic                 p3_vld_reg;
    logic                 p3_rd_reg;
    dbsi_pkg::dbsi_addr_t p3_base_reg;

    wire logic burst_start_bit0 = link.addr[0];
    wire logic burst_start_bit1 = link.addr[1];
    wire logic load_take = !link.cycle_load_n && !p1_vld_reg;
    wire dbsi_pkg::dbsi_addr_t p1_base_next =
        load_take ? {link.addr[dbsi_pkg::AW-1:2], burst_start_bit1,
                     burst_start_bit0} : p1_base_reg;
    wire logic p1_rd_next = load_take ? link.read_not_write : p1_rd_reg;

    always_ff @(posedge link.k_clk or posedge rst)
    begin
        if (rst)
        begin
            p1_vld_reg  <= 1'b0;
            p1_rd_reg   <= 1'b0;
            p1_base_reg <= dbsi_pkg::ADDR_RST;
            p2_vld_reg  <= 1'b0;
            p2_rd_reg   <= 1'b0;
            p2_base_reg <= dbsi_pkg::ADDR_RST;
            p3_vld_reg  <= 1'b0;
            p3_rd_reg   <= 1'b0;
            p3_base_reg <= dbsi_pkg::ADDR_RST;
        end
        else
        begin
            p1_vld_reg  <= load_take;
            p1_rd_reg   <= p1_rd_next;
            p1_base_reg <= p1_base_next;
            p2_vld_reg  <= p1_vld_reg;
            p2_rd_reg   <= p1_rd_reg;
            p2_base_reg <= p1_base_reg;
            p3_vld_reg  <= p2_vld_reg;
            p3_rd_reg   <= p2_rd_reg;
            p3_base_reg <= p2_base_reg;
        end
    end

    wire logic p1_wr = p1_vld_reg && !p1_rd_reg;
    wire logic p2_wr = p2_vld_reg && !p2_rd_reg;
    wire logic p3_wr = p3_vld_reg && !p3_rd_reg;
    wire logic p2_rd = p2_vld_reg && p2_rd_reg;
    wire logic p3_rd = p3_vld_reg && p3_rd_reg;

    // ------------------------------------------------------------
    // Write beats on the complement input strobe
    // ------------------------------------------------------------
    logic                 n_vld_reg;
    dbsi_pkg::dbsi_addr_t n_addr_reg;
    dbsi_pkg::dbsi_word_t n_data_reg;
    dbsi_pkg::dbsi_mask_t n_mask_reg;

    wire logic wr_neg_hit = p2_wr || p3_wr;
    wire dbsi_pkg::dbsi_addr_t wr_neg_addr =
        p2_wr ? burst_addr(p2_base_reg, 2'h1) : burst_addr(p3_base_reg, 2'h3);

    always_ff @(posedge link.k_clk_n or posedge rst)
    begin
        if (rst)
        begin
            n_vld_reg  <= 1'b0;
            n_addr_reg <= dbsi_pkg::ADDR_RST;
            n_data_reg <= dbsi_pkg::WORD_RST;
            n_mask_reg <= dbsi_pkg::MASK_NONE;
        end
        else
        begin
            n_vld_reg  <= wr_neg_hit;
            n_addr_reg <= wr_neg_addr;
            n_data_reg <= link.shared_data_lines;
            n_mask_reg <= link.byte_write_mask_n;
        end
    end

    // ------------------------------------------------------------
    // Storage: true-strobe beat plus held complement beat per edge
    // ------------------------------------------------------------
    wire logic pos_we = p1_wr || p2_wr;
    wire dbsi_pkg::dbsi_addr_t pos_addr =
        p1_wr ? burst_addr(p1_base_reg, 2'h0) : burst_addr(p2_base_reg, 2'h2);
    dbsi_pkg::dbsi_word_t mem_rd [dbsi_pkg::DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < dbsi_pkg::DEPTH; gi++)
        begin : g_cell
            dbsi_pkg::dbsi_word_t cell_reg;
            wire logic hit_n =
                n_vld_reg && (n_addr_reg == dbsi_pkg::dbsi_addr_t'(gi));
            wire logic hit_p =
                pos_we && (pos_addr == dbsi_pkg::dbsi_addr_t'(gi));
            always_ff @(posedge link.k_clk)
            begin
                cell_reg <= merge(merge(cell_reg, n_data_reg, n_mask_reg,
                    hit_n), link.shared_data_lines,
                    link.byte_write_mask_n, hit_p);
            end
            assign mem_rd[gi] = cell_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // Read launch and echo strobes
    // ------------------------------------------------------------
    wire logic use_k     = link.c_clk && link.c_clk_n;
    wire logic out_clk   = use_k ? link.k_clk : link.c_clk;
    wire logic out_clk_n = use_k ? link.k_clk_n : link.c_clk_n;
    wire dbsi_pkg::dbsi_addr_t rd_pos_addr =
        p2_rd ? burst_addr(p2_base_reg, 2'h1) : burst_addr(p3_base_reg, 2'h3);
    wire dbsi_pkg::dbsi_addr_t rd_neg_addr =
        p2_rd ? burst_addr(p2_base_reg, 2'h0) : burst_addr(p3_base_reg, 2'h2);

    dbsi_pkg::dbsi_word_t q_pos_reg;
    logic                 oe_pos_reg;
    dbsi_pkg::dbsi_word_t q_neg_reg;
    logic                 oe_neg_reg;

    always_ff @(posedge out_clk or posedge rst)
    begin
        if (rst)
        begin
            q_pos_reg  <= dbsi_pkg::WORD_RST;
            oe_pos_reg <= 1'b0;
        end
        else
        begin
            q_pos_reg  <= mem_rd[rd_pos_addr];
            oe_pos_reg <= p2_rd || p3_rd;
        end
    end

    always_ff @(posedge out_clk_n or posedge rst)
    begin
        if (rst)
        begin
            q_neg_reg  <= dbsi_pkg::WORD_RST;
            oe_neg_reg <= 1'b0;
        end
        else
        begin
            q_neg_reg  <= mem_rd[rd_neg_addr];
            oe_neg_reg <= p2_rd || p3_rd;
        end
    end

    // Double data rate output cell
    assign link.dev_data_out     = out_clk ? q_pos_reg : q_neg_reg;
    assign link.dev_data_oe      = out_clk ? oe_pos_reg : oe_neg_reg;
    assign link.echo_strobe_pair = {out_clk, out_clk_n};

    // ------------------------------------------------------------
    // Delay loop status and unused ball capture
    // ------------------------------------------------------------
    logic                       byp_meta_reg;
    logic                       byp_sync_reg;
    dbsi_pkg::dbsi_lock_t       lock_cnt_reg;
    logic                       dll_ready_reg;
    logic [dbsi_pkg::NC_W-1:0]  nc_meta_reg;
    logic [dbsi_pkg::NC_W-1:0]  nc_sync_reg;

    wire logic lock_done = lock_cnt_reg == dbsi_pkg::DLL_LOCK_CYCLES;
    wire dbsi_pkg::dbsi_lock_t lock_cnt_next =
        !byp_sync_reg ? '0 :
        lock_done     ? lock_cnt_reg :
        dbsi_pkg::dbsi_lock_t'(lock_cnt_reg + 1'b1);

    always_ff @(posedge link.k_clk or posedge rst)
    begin
        if (rst)
        begin
            byp_meta_reg  <= 1'b1;
            byp_sync_reg  <= 1'b1;
            lock_cnt_reg  <= '0;
            dll_ready_reg <= 1'b0;
            nc_meta_reg   <= '0;
            nc_sync_reg   <= '0;
        end
        else
        begin
            byp_meta_reg  <= dll_bypass_n;
            byp_sync_reg  <= byp_meta_reg;
            lock_cnt_reg  <= lock_cnt_next;
            dll_ready_reg <= !byp_sync_reg || lock_done;
            nc_meta_reg   <= nc_level;
            nc_sync_reg   <= nc_meta_reg;
        end
    end

    assign dll_ready     = dll_ready_reg;
    assign scan_nc_level = nc_sync_reg;

endmodule

// ---- hdl/dbsi_link_if.sv ----
/*
 * Link between the memory device and its controller.
 * Assumes at most one end enables the shared data lines at a time.
 */
`timescale 1ns/10ps
interface dbsi_link_if;
    logic                 k_clk;
    logic                 k_clk_n;
    logic                 c_clk;
    logic                 c_clk_n;
    logic                 cycle_load_n;
    logic                 read_not_write;
    dbsi_pkg::dbsi_addr_t addr;
    dbsi_pkg::dbsi_mask_t byte_write_mask_n;
    dbsi_pkg::dbsi_word_t shared_data_lines;
    dbsi_pkg::dbsi_word_t ctl_data_out;
    logic                 ctl_data_oe;
    dbsi_pkg::dbsi_word_t dev_data_out;
    logic                 dev_data_oe;
    logic [1:0]           echo_strobe_pair;

    // Resolved level; released lines show the inverse of the controller's last write word
    assign shared_data_lines = dev_data_oe ? dev_data_out :
                               ctl_data_oe ? ctl_data_out :
                               ~ctl_data_out;

    modport dev
    (
        input  k_clk,
        input  k_clk_n,
        input  c_clk,
        input  c_clk_n,
        input  cycle_load_n,
        input  read_not_write,
        input  addr,
        input  byte_write_mask_n,
        input  shared_data_lines,
        output dev_data_out,
        output dev_data_oe,
        output echo_strobe_pair
    );

    modport ctl
    (
        output k_clk,
        output k_clk_n,
        output c_clk,
        output c_clk_n,
        output cycle_load_n,
        output read_not_write,
        output addr,
        output byte_write_mask_n,
        input  shared_data_lines,
        output ctl_data_out,
        output ctl_data_oe,
        input  echo_strobe_pair
    );
endinterface

// ---- hdl/dbsi_pkg.sv ----
/*
 * Shared constants and types for the double data rate burst memory link:
 * widths, burst layout, controller slot schedule, reset values.
 * Assumes the x36 organisation and a small flip-flop memory array.
 */
package dbsi_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DW     = 36;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int BURST  = 4;
    localparam int AW     = 6;
    localparam int DEPTH  = 64;
    localparam int NC_W   = 4;
    localparam int LOCK_W = 11;

    typedef logic [DW-1:0]     dbsi_word_t;
    typedef logic [AW-1:0]     dbsi_addr_t;
    typedef logic [LANES-1:0]  dbsi_mask_t;
    typedef logic [1:0]        dbsi_beat_t;
    typedef logic [2:0]        dbsi_slot_t;
    typedef logic [LOCK_W-1:0] dbsi_lock_t;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam dbsi_lock_t DLL_LOCK_CYCLES = 11'h400;
    localparam dbsi_word_t WORD_RST        = 36'h0;
    localparam dbsi_addr_t ADDR_RST        = 6'h0;
    localparam dbsi_mask_t MASK_NONE       = 4'hf;
    localparam logic [1:0] PH_RST          = 2'h0;

    // Controller half-period slots of one transfer
    localparam dbsi_slot_t SLOT_LOAD    = 3'h0;
    localparam dbsi_slot_t SLOT_LOADEND = 3'h1;
    localparam dbsi_slot_t SLOT_WR_FRST = 3'h2;
    localparam dbsi_slot_t SLOT_WR_LAST = 3'h5;
    localparam dbsi_slot_t SLOT_RD_FRST = 3'h4;
    localparam dbsi_slot_t SLOT_LAST    = 3'h7;

    typedef enum logic [1:0]
    {
        CTL_IDLE = 2'b01,
        CTL_BUSY = 2'b10
    } dbsi_ctl_e;

endpackage

// ---- tb/dbsi_checker.sv ----
/*
 * Checker for the device-controller link: load spacing, bus ownership
 * per burst, echo strobes and output strobe pair.
 * Assumes read data is timed from the input strobe pair.
 */
`timescale 1ns/10ps
module dbsi_checker
(
    input wire logic       rst,
    input wire logic       k_clk,
    input wire logic       k_clk_n,
    input wire logic       c_clk,
    input wire logic       c_clk_n,
    input wire logic       cycle_load_n,
    input wire logic       read_not_write,
    input wire logic       ctl_data_oe,
    input wire logic       dev_data_oe,
    input wire logic [1:0] echo_strobe_pair
);
    default clocking cb @(posedge k_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Burst framing
    // ------------------------------------------------------------
    ld_gap_a: assert property (!cycle_load_n |=> cycle_load_n[*3])
        else $error("load repeated within a burst");
    rd_dev_a: assert property ((!cycle_load_n && read_not_write) |=>
        !dev_data_oe ##1 dev_data_oe[*2] ##1 !dev_data_oe)
        else $error("read data window misplaced");
    rd_ctl_a: assert property ((!cycle_load_n && read_not_write) |=>
        !ctl_data_oe[*4])
        else $error("controller drove during a read");
    wr_ctl_a: assert property ((!cycle_load_n && !read_not_write) |=>
        ctl_data_oe[*2] ##1 !ctl_data_oe)
        else $error("write data window misplaced");
    wr_dev_a: assert property ((!cycle_load_n && !read_not_write) |=>
        !dev_data_oe[*4])
        else $error("device drove during a write");
    bus_one_a: assert property (!(dev_data_oe && ctl_data_oe))
        else $error("both ends drive the data lines");

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    echo_k_a: assert property (echo_strobe_pair == 2'h1)
        else $error("echo pair wrong before true strobe rise");
    echo_kn_a: assert property (@(posedge k_clk_n)
        echo_strobe_pair == 2'h2)
        else $error("echo pair wrong before complement rise");
    out_ref_a: assert property (c_clk && c_clk_n)
        else $error("output strobe pair toggled");
endmodule

// ---- tb/tb.sv ----
/*
 * Bench: controller and device joined through the link interface.
 * Assumes the controller makes the link clock from clk.
 */
`timescale 1ns/10ps
module tb;
    logic                 clk;
    logic                 rst;
    logic                 req_valid;
    logic                 req_ready;
    logic                 req_read;
    dbsi_pkg::dbsi_addr_t req_addr;
    logic [143:0]         req_wdata;
    logic [15:0]          req_wmask_n;
    logic                 rsp_valid;
    logic [143:0]         rsp_rdata;
    logic                 dll_bypass_n;
    logic                 dll_ready;
    logic [3:0]           nc_level;
    logic [3:0]           scan_nc_level;
    int                   err_total;
    int                   n_compared;
    int                   cyc;
    dbsi_pkg::dbsi_word_t mem [64];

    dbsi_link_if i_dbsi_link_if();
    dbsi_ctrl i_dbsi_ctrl
    (
        .clk         (clk),
        .rst         (rst),
        .link        (i_dbsi_link_if),
        .req_valid   (req_valid),
        .req_ready   (req_ready),
        .req_read    (req_read),
        .req_addr    (req_addr),
        .req_wdata   (req_wdata),
        .req_wmask_n (req_wmask_n),
        .rsp_valid   (rsp_valid),
        .rsp_rdata   (rsp_rdata)
    );
    dbsi_device i_dbsi_device
    (
        .link          (i_dbsi_link_if),
        .rst           (rst),
        .dll_bypass_n  (dll_bypass_n),
        .dll_ready     (dll_ready),
        .nc_level      (nc_level),
        .scan_nc_level (scan_nc_level)
    );
    dbsi_checker i_dbsi_checker
    (
        .rst              (rst),
        .k_clk            (i_dbsi_link_if.k_clk),
        .k_clk_n          (i_dbsi_link_if.k_clk_n),
        .c_clk            (i_dbsi_link_if.c_clk),
        .c_clk_n          (i_dbsi_link_if.c_clk_n),
        .cycle_load_n     (i_dbsi_link_if.cycle_load_n),
        .read_not_write   (i_dbsi_link_if.read_not_write),
        .ctl_data_oe      (i_dbsi_link_if.ctl_data_oe),
        .dev_data_oe      (i_dbsi_link_if.dev_data_oe),
        .echo_strobe_pair (i_dbsi_link_if.echo_strobe_pair)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input logic [143:0] seen, input logic [143:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // One transfer; the array model gives the expected read data
    // ------------------------------------------------------------
    task automatic xfer(input logic rd, input dbsi_pkg::dbsi_addr_t a,
                        input logic [143:0] d, input logic [15:0] m);
        int                   n;
        logic [143:0]         e;
        dbsi_pkg::dbsi_addr_t w;
        req_read = rd;
        req_addr = a;
        req_wdata = d;
        req_wmask_n = m;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        if (n == 40)
            err_total++;
        @(negedge clk);
        req_valid = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            w = {a[5:2], a[1:0] + 2'(i)};
            for (int l = 0; l < 4; l++)
                if (!rd && !m[4*i+l])
                    mem[w][9*l+:9] = d[36*i+9*l+:9];
            e[36*i+:36] = mem[w];
        end
        n = 0;
        while (rd && rsp_valid !== 1'b1 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        if (n == 40)
            err_total++;
        if (rd)
            chk(rsp_rdata, e);
        @(negedge clk);
    endtask

    task automatic s_order();
        logic [143:0] d;
        for (logic [35:0] s = 36'h0; s < 36'h4; s++)
        begin
            d = {s + 36'hc0, s + 36'h80, s + 36'h40, s};
            xfer(1'b0, {4'h4 + s[3:0], s[1:0]}, d, 16'h0);
            xfer(1'b1, {4'h4 + s[3:0], s[1:0] + 2'h2}, '0, 16'hffff);
        end
    endtask

    task automatic s_mask();
        xfer(1'b0, 6'h21, {4{36'h123456789}}, 16'h0);
        xfer(1'b0, 6'h21, {4{36'hfedcba987}}, 16'hf421);
        xfer(1'b1, 6'h20, '0, 16'hffff);
    endtask

    task automatic s_nc();
        nc_level = 4'h5;
        repeat (16) @(negedge clk);
        chk(scan_nc_level, 4'h5);
        nc_level = 4'ha;
        repeat (16) @(negedge clk);
        chk(scan_nc_level, 4'ha);
    endtask

    task automatic s_dll();
        dll_bypass_n = 1'b0;
        repeat (24) @(negedge clk);
        chk(dll_ready, 1'b1);
        dll_bypass_n = 1'b1;
        repeat (24) @(negedge clk);
        chk(dll_ready, 1'b0);
        repeat (4200) @(negedge clk);
        chk(dll_ready, 1'b1);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_addr = 6'h0;
        req_wdata = '0;
        req_wmask_n = 16'hffff;
        dll_bypass_n = 1'b1;
        nc_level = 4'h0;
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        s_order();
        s_mask();
        s_nc();
        s_dll();
        conclude();
    end
endmodule
